// ---- disk_ctrl_pkg.sv ----
// constants, pin bundles and state record for the disk drive unit controller
// assumes a 125 MHz clock and one drive pin bundle per controller
package disk_ctrl_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 125;
    localparam int STEP_MIN_US = 10;
    localparam int STEP_CYC = STEP_MIN_US * CLK_MHZ;
    localparam int STEP_GAP_MS = 10;
    localparam int SETTLE_MS = 10;
    localparam int BIT_RATE = 500000;
    localparam int CELL_CYC = (CLK_MHZ * 1000000) / BIT_RATE;
    localparam int HALF_CYC = CELL_CYC / 2;
    localparam int WIN_CYC = CELL_CYC / 4;
    localparam int WPULSE_NS = 250;
    localparam int WPULSE_CYC = (WPULSE_NS * CLK_MHZ) / 1000;
    // ****************************************
    // tracks and retries
    // ****************************************
    localparam logic [6:0] LOW_CUR_TRACK = 7'h2B;
    localparam logic [6:0] MAX_TRACK = 7'h4C;
    localparam logic [3:0] WR_ATTEMPTS = 4'h4;
    localparam logic [3:0] RD_ATTEMPTS = 4'hA;
    // ****************************************
    // register indices and fields
    // ****************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_SEEK = 4'h1;
    localparam logic [3:0] REG_WDATA = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_TRACK = 4'h4;
    localparam logic [3:0] REG_RDATA = 4'h5;
    localparam logic [3:0] REG_RETRY = 4'h6;
    localparam logic [3:0] REG_INDEX = 4'h7;
    localparam int CTRL_WGATE = 2;
    localparam int CTRL_FCLR = 3;
    localparam int SEEK_RECAL = 7;
    localparam int RETRY_WR = 0;
    localparam int RETRY_RD = 1;
    localparam int RETRY_CLR = 2;
    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic step;
        logic dir;
        logic [1:0] sel;
        logic wgate;
        logic wdata;
        logic low_cur;
        logic fault_clr;
    } drive_out_t;
    typedef struct packed {
        logic index;
        logic wfault;
        logic outermost_track;
        logic [1:0] ready;
        logic wprot;
        logic rdata;
    } drive_in_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_PULSE = 3'b010,
        ST_GAP = 3'b011,
        ST_SETTLE = 3'b100
    } seek_st_t;
    typedef struct packed {
        seek_st_t st;
        logic [23:0] tcnt;
        logic [6:0] track;
        logic [6:0] target;
        logic recal;
        logic [1:0] sel;
        logic wgate;
        logic fclr;
        logic step;
        logic dir;
        logic low_cur;
        logic [7:0] wsh;
        logic [7:0] wbuf;
        logic wbuf_full;
        logic [2:0] wbit;
        logic [7:0] wcnt;
        logic [5:0] wpw;
        logic wout;
        logic prev_d;
        logic prev_c;
        logic [2:0] rsync;
        logic [7:0] rcnt;
        logic rseen;
        logic [7:0] rsh;
        logic [2:0] rbit;
        logic [7:0] rbyte;
        logic rvalid;
        logic rover;
        logic [5:0] in_m;
        logic [5:0] in_s;
        logic idx_prev;
        logic [7:0] idx_cnt;
        logic [3:0] wr_fail;
        logic [3:0] rd_fail;
        logic [7:0] rdq;
    } ctl_state_t;
endpackage

// ---- disk_ctrl.sv ----
// controller that drives one pair of disk drive units through their pins
// assumes drive inputs are asynchronous and software uses the plain register port
// Behaviour
// - step pulses high at least 10 us
// - direction high steps inward, low outward
// - never select both drive units at once
// - unit select held through every command
// - record gate high writes, low reads
// - write pulses high for 250 ns
// - modified double density code, clock and data interleaved
// - 500 kbit/s, 2 us bit cell
// - reduced current for target tracks above 43
// - read pulses 250 ns, controller separates clock
// - steps 10 ms apart, then 10 ms settle
// - recalibrate steps outward until outermost track
// - count read retries up to 10
// - count write attempts, defective after 4
`timescale 1ns/1ps
module disk_ctrl #(
    parameter int STEP_GAP_CYC = disk_ctrl_pkg::STEP_GAP_MS * disk_ctrl_pkg::CLK_MHZ * 1000,
    parameter int SETTLE_CYC = disk_ctrl_pkg::SETTLE_MS * disk_ctrl_pkg::CLK_MHZ * 1000
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output disk_ctrl_pkg::drive_out_t drv_o,
    input wire disk_ctrl_pkg::drive_in_t drv_i
);
    import disk_ctrl_pkg::*;

    ctl_state_t s_q;
    ctl_state_t s_d;
    logic trk00;
    logic busy;
    logic redge;
    logic cur_clk;

    // synchronised track 00 level, busy, read pulse edge and write clock bit
    assign trk00 = s_q.in_s[3];
    assign busy = (s_q.st != ST_IDLE);
    assign redge = s_q.rsync[1] & ~s_q.rsync[2];
    assign cur_clk = ~s_q.prev_d & ~s_q.wsh[7] & ~s_q.prev_c;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.fclr = 1'b0;
        s_d.rdq = 8'h00;
        // two-flop synchronisers for all drive inputs
        s_d.in_m = {drv_i.index, drv_i.wfault, drv_i.outermost_track, drv_i.ready,
            drv_i.wprot};
        s_d.in_s = s_q.in_m;
        s_d.rsync = {s_q.rsync[1:0], drv_i.rdata};
        // revolution counter
        s_d.idx_prev = s_q.in_s[5];
        if (s_q.in_s[5] && !s_q.idx_prev) begin
            s_d.idx_cnt = s_q.idx_cnt + 8'h01;
        end

        // head positioner
        case (s_q.st)
            ST_IDLE: begin
                s_d.step = 1'b0;
            end
            ST_SETUP: begin
                s_d.tcnt = 24'h000000;
                if (s_q.recal) begin
                    if (trk00) begin
                        s_d.track = 7'h00;
                        s_d.recal = 1'b0;
                        s_d.st = ST_SETTLE;
                    end else begin
                        s_d.dir = 1'b0;
                        s_d.st = ST_PULSE;
                    end
                end else if (s_q.target == s_q.track) begin
                    s_d.st = ST_SETTLE;
                end else begin
                    s_d.dir = (s_q.target > s_q.track);
                    s_d.st = ST_PULSE;
                end
            end
            ST_PULSE: begin
                // dir changed one cycle earlier, stays put while step is high
                s_d.tcnt = s_q.tcnt + 24'h000001;
                s_d.step = 1'b1;
                if (s_q.tcnt == 24'(STEP_CYC)) begin
                    s_d.step = 1'b0;
                    s_d.tcnt = 24'h000000;
                    s_d.st = ST_GAP;
                    if (s_q.dir) begin
                        s_d.track = s_q.track + 7'h01;
                    end else if (s_q.track != 7'h00) begin
                        s_d.track = s_q.track - 7'h01;
                    end
                end
            end
            ST_GAP: begin
                s_d.tcnt = s_q.tcnt + 24'h000001;
                if (s_q.tcnt >= 24'(STEP_GAP_CYC - 1)) begin
                    s_d.st = ST_SETUP;
                end
            end
            ST_SETTLE: begin
                s_d.tcnt = s_q.tcnt + 24'h000001;
                if (s_q.tcnt >= 24'(SETTLE_CYC - 1)) begin
                    s_d.st = ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase

        // write serializer, one bit cell per CELL_CYC cycles
        if (s_q.wpw != 6'h00) begin
            s_d.wpw = s_q.wpw - 6'h01;
            if (s_q.wpw == 6'h01) begin
                s_d.wout = 1'b0;
            end
        end
        if (!s_q.wgate) begin
            s_d.wcnt = 8'h00;
            s_d.wbit = 3'h0;
            s_d.wsh = 8'h00;
            s_d.prev_d = 1'b0;
            s_d.prev_c = 1'b0;
            s_d.wout = 1'b0;
            s_d.wpw = 6'h00;
        end else begin
            s_d.wcnt = (s_q.wcnt == 8'(CELL_CYC - 1)) ? 8'h00 : s_q.wcnt + 8'h01;
            if (s_q.wcnt == 8'h00) begin
                // clock pulse only between zeros and not after a clock
                s_d.prev_c = cur_clk;
                if (cur_clk) begin
                    s_d.wout = 1'b1;
                    s_d.wpw = 6'(WPULSE_CYC);
                end
            end
            if (s_q.wcnt == 8'(HALF_CYC) && s_q.wsh[7]) begin
                s_d.wout = 1'b1;
                s_d.wpw = 6'(WPULSE_CYC);
            end
            if (s_q.wcnt == 8'(CELL_CYC - 1)) begin
                s_d.prev_d = s_q.wsh[7];
                s_d.wbit = s_q.wbit + 3'h1;
                s_d.wsh = {s_q.wsh[6:0], 1'b0};
                if (s_q.wbit == 3'h7) begin
                    // underrun sends zero bytes
                    s_d.wsh = s_q.wbuf_full ? s_q.wbuf : 8'h00;
                    s_d.wbuf_full = 1'b0;
                end
            end
        end

        // read separator: pulses near mid cell are data, others are clock
        if (s_q.wgate) begin
            s_d.rcnt = 8'h00;
            s_d.rseen = 1'b0;
            s_d.rbit = 3'h0;
        end else begin
            s_d.rcnt = (s_q.rcnt == 8'(CELL_CYC - 1)) ? 8'h00 : s_q.rcnt + 8'h01;
            if (s_q.rcnt == 8'(CELL_CYC - 1)) begin
                s_d.rsh = {s_q.rsh[6:0], s_q.rseen};
                s_d.rseen = 1'b0;
                s_d.rbit = s_q.rbit + 3'h1;
                if (s_q.rbit == 3'h7) begin
                    s_d.rbyte = {s_q.rsh[6:0], s_q.rseen};
                    s_d.rover = s_q.rvalid;
                end
            end
            if (redge) begin
                if (s_q.rcnt >= 8'(HALF_CYC - WIN_CYC) && s_q.rcnt <= 8'(HALF_CYC + WIN_CYC)) begin
                    s_d.rseen = 1'b1;
                    s_d.rcnt = 8'(HALF_CYC + 1);
                end else begin
                    s_d.rcnt = 8'h01;
                end
            end
        end

        // register writes
        if (wr) begin
            case (addr)
                REG_CTRL: begin
                    if (!busy && wdata[1:0] != 2'b11) begin
                        s_d.sel = wdata[1:0];
                    end
                    s_d.wgate = wdata[CTRL_WGATE];
                    s_d.fclr = wdata[CTRL_FCLR];
                end
                REG_SEEK: begin
                    if (!busy && wdata[6:0] <= MAX_TRACK) begin
                        s_d.target = wdata[SEEK_RECAL] ? 7'h00 : wdata[6:0];
                        s_d.recal = wdata[SEEK_RECAL];
                        s_d.st = ST_SETUP;
                    end
                end
                REG_WDATA: begin
                    if (!s_q.wbuf_full || !s_d.wbuf_full) begin
                        s_d.wbuf = wdata;
                        s_d.wbuf_full = 1'b1;
                    end
                end
                REG_RETRY: begin
                    if (wdata[RETRY_CLR]) begin
                        s_d.wr_fail = 4'h0;
                        s_d.rd_fail = 4'h0;
                    end else begin
                        if (wdata[RETRY_WR] && s_q.wr_fail < WR_ATTEMPTS) begin
                            s_d.wr_fail = s_q.wr_fail + 4'h1;
                        end
                        if (wdata[RETRY_RD] && s_q.rd_fail < RD_ATTEMPTS) begin
                            s_d.rd_fail = s_q.rd_fail + 4'h1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // reduced current follows the target track
        s_d.low_cur = (s_d.target > LOW_CUR_TRACK);

        // register reads, data in the following cycle
        if (rd) begin
            case (addr)
                REG_CTRL: s_d.rdq = {4'h0, s_q.fclr, s_q.wgate, s_q.sel};
                REG_SEEK: s_d.rdq = {s_q.recal, s_q.target};
                REG_STATUS: s_d.rdq = {busy, s_q.in_s[4], s_q.in_s[3], s_q.in_s[2:1],
                    s_q.in_s[0], s_q.wbuf_full, s_q.rvalid};
                REG_TRACK: s_d.rdq = {1'b0, s_q.track};
                REG_RDATA: s_d.rdq = s_q.rbyte;
                REG_RETRY: s_d.rdq = {s_q.rd_fail, s_q.wr_fail};
                REG_INDEX: s_d.rdq = s_q.idx_cnt;
                default: s_d.rdq = {5'h00, s_q.rover, (s_q.rd_fail >= RD_ATTEMPTS),
                    (s_q.wr_fail >= WR_ATTEMPTS)};
            endcase
            if (addr == REG_RDATA) begin
                s_d.rvalid = 1'b0;
                s_d.rover = 1'b0;
            end
        end
        // a byte landing in the same cycle as its read stays flagged
        if (!s_q.wgate && s_q.rcnt == 8'(CELL_CYC - 1) && s_q.rbit == 3'h7) begin
            s_d.rvalid = 1'b1;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign rdata = s_q.rdq;
    assign drv_o.step = s_q.step;
    assign drv_o.dir = s_q.dir;
    assign drv_o.sel = s_q.sel;
    assign drv_o.wgate = s_q.wgate;
    assign drv_o.wdata = s_q.wout;
    assign drv_o.low_cur = s_q.low_cur;
    assign drv_o.fault_clr = s_q.fclr;

    // ****************************************
    // checks
    // ****************************************
    logic [23:0] step_len;
    logic [23:0] gap_len;
    logic [7:0] wp_len;

    // pulse and spacing counters seen only by the checks
    always_ff @(posedge clock) begin
        if (srst) begin
            step_len <= 24'h000000;
            gap_len <= 24'hFFFFFF;
            wp_len <= 8'h00;
        end else begin
            step_len <= s_q.step ? step_len + 24'h000001 : 24'h000000;
            gap_len <= s_q.step ? 24'h000000 : ((gap_len == 24'hFFFFFF) ? gap_len
                : gap_len + 24'h000001);
            wp_len <= s_q.wout ? wp_len + 8'h01 : 8'h00;
        end
    end

    a_step_width: assert property (@(posedge clock) disable iff (srst)
        $fell(s_q.step) |-> step_len >= 24'(STEP_CYC))
        else $error("step pulse too short");
    a_dir_before_step: assert property (@(posedge clock) disable iff (srst)
        $rose(s_q.step) |-> $stable(s_q.dir))
        else $error("direction changed with step edge");
    a_dir_held: assert property (@(posedge clock) disable iff (srst)
        s_q.step && $past(s_q.step) |-> $stable(s_q.dir))
        else $error("direction changed during step");
    a_one_unit: assert property (@(posedge clock) disable iff (srst)
        s_q.sel != 2'b11)
        else $error("both units selected");
    a_sel_held: assert property (@(posedge clock) disable iff (srst)
        busy && $past(busy) |-> $stable(s_q.sel))
        else $error("unit select changed during command");
    a_write_gated: assert property (@(posedge clock) disable iff (srst)
        s_q.wout |-> s_q.wgate)
        else $error("write pulse without record gate");
    a_wpulse_width: assert property (@(posedge clock) disable iff (srst)
        $fell(s_q.wout) && s_q.wgate |-> wp_len == 8'(WPULSE_CYC))
        else $error("write pulse width wrong");
    a_cell_phase: assert property (@(posedge clock) disable iff (srst)
        $rose(s_q.wout) |-> s_q.wcnt == 8'h01 || s_q.wcnt == 8'(HALF_CYC + 1))
        else $error("write pulse off bit cell grid");
    a_step_spacing: assert property (@(posedge clock) disable iff (srst)
        $rose(s_q.step) |-> gap_len >= 24'(STEP_GAP_CYC))
        else $error("steps too close");
    a_recal_out: assert property (@(posedge clock) disable iff (srst)
        s_q.step && s_q.recal |-> !s_q.dir)
        else $error("recalibrate stepped inward");
    a_low_current: assert property (@(posedge clock) disable iff (srst)
        s_q.wgate && s_q.target > LOW_CUR_TRACK |-> s_q.low_cur)
        else $error("reduced current missing on inner track");
    a_write_limit: assert property (@(posedge clock) disable iff (srst)
        s_q.wr_fail <= WR_ATTEMPTS && s_q.rd_fail <= RD_ATTEMPTS)
        else $error("attempt counter beyond limit");
endmodule

// ---- drive_model.sv ----
// behavioural disk drive unit facing the controller pins
// assumes the bench shortens the step gap and the revolution time
`timescale 1ns/1ps
module drive_model #(
    parameter int GAP = 200,
    parameter int REV = 3000
) (
    input wire logic clock,
    input wire disk_ctrl_pkg::drive_out_t o,
    input wire logic head_in,
    input wire logic rd_on,
    input wire logic [1:0] rdy,
    input wire logic prot,
    output disk_ctrl_pkg::drive_in_t i,
    output int track,
    output int bad,
    output int quiet
);
    import disk_ctrl_pkg::*;
    int t = 0;
    int hi = 0;
    int whi = 0;
    int wgap = 0;
    logic fault = 1'b0;
    logic seen = 1'b0;
    logic ps = 1'b0;
    logic pw = 1'b0;
    logic pdir = 1'b0;
    logic [1:0] psel = 2'h0;
    logic erase;
    logic cur_low;
    int trk = 2;
    int qt = 100000;
    int bad_s = 0;
    int bad_w = 0;
    wire picked = |o.sel;
    // one driver each for the observed counters
    assign track = trk;
    assign quiet = qt;
    assign bad = bad_s + bad_w;
    // ****************************************
    // lines toward the controller
    // ****************************************
    // erase and reduced current follow the record gate, never when protected
    assign erase = o.wgate && !prot;
    assign cur_low = o.low_cur && erase;
    // a deselected unit shows false on its status lines except ready, which follows rdy
    assign i.index = picked && ((t % REV) < 200);
    assign i.wfault = picked && fault;
    assign i.outermost_track = picked && track == 0;
    assign i.ready = rdy;
    assign i.wprot = picked && prot;
    assign i.rdata = picked && rd_on && !o.wgate && ((t % CELL_CYC) < WPULSE_CYC);
    // ****************************************
    // head motion and pin checks
    // ****************************************
    // one track per step rise, counts short steps, close steps and direction changes during a step in bad
    always @(posedge clock) begin
        t <= t + 1;
        ps <= o.step;
        pdir <= o.dir;
        psel <= o.sel;
        hi <= o.step ? hi + 1 : 0;
        qt <= qt + 1;
        if (o.sel == 2'h3 || (o.step && o.sel != psel)) bad_s <= bad_s + 1;
        if (o.step && !ps) begin
            trk <= o.dir ? trk + 1 : (trk > 0 ? trk - 1 : 0);
            qt <= 0;
            if (qt < STEP_CYC + GAP) bad_s <= bad_s + 1;
        end
        if (o.step && ps && o.dir != pdir) bad_s <= bad_s + 1;
        if (!o.step && ps && hi < STEP_CYC) bad_s <= bad_s + 1;
    end
    // write pulse width and spacing, fault latch
    always @(posedge clock) begin
        pw <= o.wdata;
        whi <= o.wdata ? whi + 1 : 0;
        wgap <= o.wgate ? wgap + 1 : 0;
        if (!o.wgate) seen <= 1'b0;
        // a pulse cut by the record gate dropping is ignored by the drive
        if (!o.wdata && pw && o.wgate && (whi < 25 || whi > 37)) bad_w <= bad_w + 1;
        if (o.wdata && !pw) begin
            wgap <= 1;
            seen <= o.wgate;
            if (seen && o.wgate && (wgap % HALF_CYC != 0 || wgap < CELL_CYC
                    || wgap > 5 * HALF_CYC)) bad_w <= bad_w + 1;
        end
        if (o.wgate && (!head_in || wgap > 3 * CELL_CYC)) fault <= 1'b1;
        if (o.fault_clr) fault <= 1'b0;
    end
endmodule

// ---- testbench.sv ----
// self-checking bench for the disk controller
// assumes drive_model and shortened seek timing
`timescale 1ns/1ps
module testbench;
    import disk_ctrl_pkg::*;
    localparam int GAP = 200;
    localparam int REV = 3000;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic head_in = 1'b1;
    logic rd_on = 1'b0;
    logic prot = 1'b0;
    logic [1:0] rdy = 2'h1;
    logic [7:0] rdata;
    logic [7:0] rv;
    logic [7:0] r0;
    drive_out_t drv_o;
    drive_in_t drv_i;
    int track;
    int bad;
    int quiet;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    int m;
    integer seed = 32'h2E98D79F;
    disk_ctrl #(.STEP_GAP_CYC(GAP), .SETTLE_CYC(GAP)) dut (.clock(clock), .srst(srst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .drv_o(drv_o),
        .drv_i(drv_i));
    drive_model #(.GAP(GAP), .REV(REV)) drive (.clock(clock), .o(drv_o), .head_in(head_in),
        .rd_on(rd_on), .rdy(rdy), .prot(prot), .i(drv_i), .track(track), .bad(bad),
        .quiet(quiet));
    // ****************************************
    // clock, timeout and tasks
    // ****************************************
    initial begin
        forever #4 clock = ~clock;
    end
    // cut a hang short
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one strobe cycle, returns just after the taking edge
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // seek with a refused second order while busy
    task automatic seek(input logic [7:0] tgt, input logic [7:0] extra);
        logic [7:0] e;
        e = tgt[7] ? 8'h00 : tgt;
        wreg(REG_SEEK, tgt);
        wreg(REG_SEEK, extra);
        rreg(REG_STATUS, rv);
        for (int k = 0; k < 40000 && rv[7]; k++) rreg(REG_STATUS, rv);
        check("outermost", {7'h00, e == 8'h00}, {7'h00, rv[5]});
        rreg(REG_TRACK, rv);
        check("track reg", e, rv);
        check("head track", e, track[7:0]);
        check("settle", 8'h01, {7'h00, quiet >= STEP_CYC + GAP});
        if (!tgt[7]) check("low current", {7'h00, e > 8'h2B}, {7'h00, drv_o.low_cur});
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        check("pins after reset", 8'h00, drv_o);
        wreg(REG_CTRL, 8'h01);
        wreg(REG_CTRL, 8'h03);
        check("unit select", 8'h01, {6'h00, drv_o.sel});
        $display("test select done");
        seek(8'h80, 8'h05);
        seek(8'h03, 8'h0A);
        seek(8'(1 + {$random(seed)} % 6), 8'h07);
        wreg(REG_SEEK, 8'h4D);
        rreg(REG_STATUS, rv);
        check("busy on bad track", 8'h00, {7'h00, rv[7]});
        $display("test seek done");
        for (int k = 43; k < 45; k++) begin
            wreg(REG_SEEK, 8'(k));
            repeat (4) @(posedge clock);
            #1;
            check("low current", {7'h00, k > 43}, {7'h00, drv_o.low_cur});
            check("direction", 8'h01, {7'h00, drv_o.dir});
            repeat (1300) @(posedge clock);
            srst <= 1'b1;
            repeat (3) @(posedge clock);
            srst <= 1'b0;
            #1;
            check("pins after reset", 8'h00, drv_o);
            // reset forgets the last step, so keep the step spacing here
            repeat (GAP) @(posedge clock);
            wreg(REG_CTRL, 8'h01);
            seek(8'h80, 8'h2C);
        end
        $display("test reset mid seek done");
        wreg(REG_CTRL, 8'h05);
        for (int k = 0; k < 4; k++) begin
            rreg(REG_STATUS, rv);
            while (rv[1]) rreg(REG_STATUS, rv);
            wreg(REG_WDATA, 8'($random(seed)));
        end
        repeat (8 * CELL_CYC) @(posedge clock);
        rreg(REG_STATUS, rv);
        check("fault while writing", 8'h00, {7'h00, rv[6]});
        head_in <= 1'b0;
        repeat (8) @(posedge clock);
        rreg(REG_STATUS, rv);
        check("fault head not loaded", 8'h01, {7'h00, rv[6]});
        head_in <= 1'b1;
        wreg(REG_CTRL, 8'h09);
        repeat (8) @(posedge clock);
        rreg(REG_STATUS, rv);
        check("fault cleared", 8'h00, {7'h00, rv[6]});
        check("record gate", 8'h00, {7'h00, drv_o.wgate});
        $display("test write done");
        rd_on <= 1'b1;
        repeat (30 * CELL_CYC) @(posedge clock);
        rd_on <= 1'b0;
        rreg(REG_STATUS, rv);
        check("byte ready", 8'h01, {7'h00, rv[0]});
        rreg(REG_RDATA, rv);
        rreg(REG_STATUS, rv);
        check("byte taken", 8'h00, {7'h00, rv[0]});
        $display("test read done");
        for (int k = 0; k < 2; k++) begin
            n = k ? 4 : {$random(seed)} % 5;
            m = k ? 10 : {$random(seed)} % 11;
            repeat (n) wreg(REG_RETRY, 8'h01);
            repeat (m) wreg(REG_RETRY, 8'h02);
            rreg(REG_RETRY, rv);
            check("retry counts", {m[3:0], n[3:0]}, rv);
            wreg(REG_RETRY, 8'h04);
            rreg(REG_RETRY, rv);
            check("retry clear", 8'h00, rv);
        end
        $display("test retry done");
        rdy <= 2'($random(seed));
        prot <= 1'($random(seed));
        repeat (4) @(posedge clock);
        rreg(REG_STATUS, rv);
        check("ready and protect", {5'h00, rdy, prot}, {5'h00, rv[4:2]});
        rreg(REG_INDEX, r0);
        repeat (2 * REV - 1) @(posedge clock);
        rreg(REG_INDEX, rv);
        check("revolutions", 8'h02, rv - r0);
        $display("test status done");
        check("wire faults", 8'h00, {7'h00, bad != 0});
        end_sim();
    end
endmodule
